// ===== src/usc_pkg.sv
// Package of constants and types for the serial status and clock select
// Assumes a single peripheral clock and an 8-bit CPU data bus
package usc_pkg;
	localparam logic [15:0] ERR_STATUS_ADDR = 16'hFF53;
	localparam logic [15:0] TX_STATUS_ADDR = 16'hFF55;
	localparam logic [15:0] CLK_SEL_ADDR = 16'hFF56;
	localparam logic [2:0] ERR_RESET = 3'h0;
	localparam logic [3:0] CLK_SEL_RESET = 4'h0;
	localparam int PE_POS = 2;
	localparam int FE_POS = 1;
	localparam int OVE_POS = 0;
	localparam int TXBF_POS = 1;
	localparam int TXSF_POS = 0;
	localparam int DIV_W = 10;
	localparam logic [3:0] SEL_TIMER = 4'hB;
	localparam int FIFO_DEPTH = 32;
	localparam int DATA_W = 8;

	// Parity modes of the operation mode register
	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_ZERO = 2'h1,
		PAR_ODD = 2'h2,
		PAR_EVEN = 2'h3
	} usc_parity_type;

	// Completed frame from the receive shifter
	typedef struct packed {
		logic done;
		logic [7:0] data;
		logic parity_bit;
		logic stop_bit;
	} usc_rx_frame_type;

	// CPU bus request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} usc_bus_req_type;

	// Whole state of the status block
	typedef struct packed {
		logic [2:0] err;
		logic txbf;
		logic txsf;
		logic [3:0] clk_sel;
		logic [DIV_W-1:0] div_cnt;
		logic tm_q;
		logic [7:0] rdata;
		logic [7:0] txb_data;
		logic [7:0] tx_data;
		logic tx_load;
	} usc_state_type;
endpackage

// ===== src/usc_fifo.sv
// Synchronous FIFO with valid/ready on both sides
// Assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module usc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clear,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} usc_fifo_state_type;
	usc_fifo_state_type st_reg, st_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	// Handshakes from the fill count
	assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
	assign out_valid = st_reg.cnt != '0;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[st_reg.rp];

	// Pointer and count update
	always_comb begin
		st_next = st_reg;
		if (push)
			st_next.wp = st_reg.wp + 1'b1;
		if (pop)
			st_next.rp = st_reg.rp + 1'b1;
		if (push && !pop)
			st_next.cnt = st_reg.cnt + 1'b1;
		else if (pop && !push)
			st_next.cnt = st_reg.cnt - 1'b1;
		if (clear)
			st_next = '0;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Storage, written only on accepted words
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[st_reg.wp] <= in_data;
	end
endmodule
`default_nettype wire

// ===== src/usc_uart_status.sv
// Receive error status, transmit status and base clock select of the UART
// Assumes mode bits and shifter events come from logic on clk_sys
// Behaviour
// - Error status reads zero in bits 7..3, parity, framing, overrun below
// - Parity mismatch at frame completion sets the parity error flag
// - Error flags clear on power off, receive disable or status read
// - Missing stop bit at frame completion sets the framing error flag
// - Only the first stop bit is examined for framing errors
// - Completion while the 32-entry receive buffer is full sets the overrun flag
// - On overrun the new character is dropped, old data is kept
// - Parity checking depends on the parity mode field
// - Zero parity mode never checks parity nor sets the parity flag
// - Error status read inserts a wait; not read with peripheral clock stopped
// - Transmit status holds buffer-full bit 1, busy bit 0, clears when off
// - Buffer-full sets on buffer write, clears on move into shifter
// - Busy sets on move into shifter, clears at frame end without refill
// - Clock select holds 4 bits, upper bits read zero, resets to zero
// - Codes 0..10 divide by two to the code, 11 picks the timer
// - Rewriting the same clock select value does not disturb traffic
// - Power off stops the base clock and clears both status registers
`timescale 1ns/1ns
`default_nettype none
module usc_uart_status (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire usc_pkg::usc_bus_req_type bus_req,
	output logic [7:0] bus_rdata,
	output logic bus_wait,
	input wire logic interface_power_bit,
	input wire logic receive_enable_bit,
	input wire logic transmit_enable_bit,
	input wire usc_pkg::usc_parity_type parity_mode,
	input wire logic char_len8,
	input wire logic timer_out,
	output logic base_clk_en,
	input wire usc_pkg::usc_rx_frame_type rx_frame,
	output logic rx_out_valid,
	input wire logic rx_out_ready,
	output logic [7:0] rx_out_data,
	input wire logic txb_wr,
	input wire logic [7:0] txb_wdata,
	output logic tx_load,
	output logic [7:0] tx_data,
	input wire logic tx_frame_done
);
	import usc_pkg::*;

	usc_state_type st_reg, st_next;
	logic rx_on, tx_on, rx_eval, par_err, fifo_ready, fifo_clear;
	logic rd_err, rd_tx, rd_sel, wr_sel, tm_rise, tick, move;
	logic [DIV_W-1:0] div_mask;
	logic [7:0] rx_data_m;

	// Unit enables from the mode bits
	assign rx_on = interface_power_bit & receive_enable_bit;
	assign tx_on = interface_power_bit & transmit_enable_bit;

	// Address decode of the three registers
	assign rd_err = bus_req.rd & (bus_req.addr == ERR_STATUS_ADDR);
	assign rd_tx = bus_req.rd & (bus_req.addr == TX_STATUS_ADDR);
	assign rd_sel = bus_req.rd & (bus_req.addr == CLK_SEL_ADDR);
	assign wr_sel = bus_req.wr & (bus_req.addr == CLK_SEL_ADDR);

	// Error status read stretches the CPU access by one cycle
	assign bus_wait = rd_err;

	// Base clock enable from divider taps or timer edge
	assign div_mask = DIV_W'((11'h001 << st_reg.clk_sel) - 11'h001);
	assign tm_rise = timer_out & ~st_reg.tm_q;
	always_comb begin
		tick = 1'b0;
		if (!interface_power_bit)
			tick = 1'b0;
		else if (st_reg.clk_sel == SEL_TIMER)
			tick = tm_rise;
		else if (st_reg.clk_sel < SEL_TIMER)
			tick = (st_reg.div_cnt & div_mask) == div_mask;
	end
	assign base_clk_en = tick;

	// Frame evaluation and parity check
	assign rx_eval = rx_on & rx_frame.done & tick;
	assign rx_data_m = char_len8 ? rx_frame.data : {1'b0, rx_frame.data[6:0]};
	always_comb begin
		case (parity_mode)
		PAR_ODD:
			par_err = ~(^rx_data_m ^ rx_frame.parity_bit);
		PAR_EVEN:
			par_err = ^rx_data_m ^ rx_frame.parity_bit;
		PAR_ZERO:
			par_err = 1'b0;
		default:
			par_err = 1'b0;
		endcase
	end

	// Move from transmit buffer into the shifter on a base clock edge
	assign move = tx_on & tick & st_reg.txbf & (~st_reg.txsf | tx_frame_done);

	// Next state of the whole block
	always_comb begin
		st_next = st_reg;
		st_next.tm_q = timer_out;
		st_next.tx_load = 1'b0;
		st_next.div_cnt = interface_power_bit ? st_reg.div_cnt + 1'b1 : '0;
		// Clock select write; same value leaves the divider running
		if (wr_sel)
			st_next.clk_sel = bus_req.wdata[3:0];
		// Error flags, event wins over the read clear
		if (rd_err)
			st_next.err = ERR_RESET;
		if (rx_eval) begin
			if (par_err)
				st_next.err[PE_POS] = 1'b1;
			if (!rx_frame.stop_bit)
				st_next.err[FE_POS] = 1'b1;
			if (!fifo_ready)
				st_next.err[OVE_POS] = 1'b1;
		end
		if (!rx_on)
			st_next.err = ERR_RESET;
		// Transmit buffer and shifter flags
		if (tx_on && txb_wr) begin
			st_next.txbf = 1'b1;
			st_next.txb_data = txb_wdata;
		end
		if (tx_on && tick && tx_frame_done && !move)
			st_next.txsf = 1'b0;
		if (move) begin
			st_next.txbf = txb_wr;
			st_next.txsf = 1'b1;
			st_next.tx_data = st_reg.txb_data;
			st_next.tx_load = 1'b1;
		end
		if (!tx_on) begin
			st_next.txbf = 1'b0;
			st_next.txsf = 1'b0;
		end
		// Read data, reserved bits zero
		st_next.rdata = 8'h00;
		if (rd_err)
			st_next.rdata = {5'h00, st_reg.err};
		else if (rd_tx)
			st_next.rdata = {6'h00, st_reg.txbf, st_reg.txsf};
		else if (rd_sel)
			st_next.rdata = {4'h0, st_reg.clk_sel};
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
			st_reg.clk_sel <= CLK_SEL_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus_rdata = st_reg.rdata;
	assign tx_load = st_reg.tx_load;
	assign tx_data = st_reg.tx_data;

	// Receive buffer; a full buffer drops the new character
	assign fifo_clear = ~rx_on;
	usc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clear(fifo_clear),
		.in_valid(rx_eval),
		.in_ready(fifo_ready),
		.in_data(rx_data_m),
		.out_valid(rx_out_valid),
		.out_ready(rx_out_ready),
		.out_data(rx_out_data)
	);

	// Checks on the status flags and clock selection
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	property p_err_upper_zero;
		rd_err |=> bus_rdata[7:3] == 5'h00 && bus_rdata[2:0] == $past(st_reg.err);
	endproperty
	a_err_upper_zero: assert property (p_err_upper_zero)
		else $error("error status read data wrong");

	property p_parity_set;
		rx_eval && par_err |=> st_reg.err[PE_POS];
	endproperty
	a_parity_set: assert property (p_parity_set)
		else $error("parity flag not set");

	property p_err_clear_off;
		!rx_on |=> st_reg.err == 3'h0;
	endproperty
	a_err_clear_off: assert property (p_err_clear_off)
		else $error("error flags survive disable");

	property p_read_clears;
		rd_err && !rx_eval ##1 !rx_eval |-> ##1 st_reg.err == 3'h0;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("read did not clear errors");

	property p_framing;
		rx_eval && !rx_frame.stop_bit |=> st_reg.err[FE_POS];
	endproperty
	a_framing: assert property (p_framing)
		else $error("framing flag not set");

	property p_overrun_drop;
		rx_eval && !fifo_ready |=> st_reg.err[OVE_POS] && !rx_out_valid == 1'b0;
	endproperty
	a_overrun_drop: assert property (p_overrun_drop)
		else $error("overrun not flagged");

	property p_zero_parity;
		rx_eval && parity_mode == PAR_ZERO && !st_reg.err[PE_POS]
			|=> !st_reg.err[PE_POS];
	endproperty
	a_zero_parity: assert property (p_zero_parity)
		else $error("parity flagged in zero mode");

	property p_wait;
		bus_wait == (bus_req.rd && bus_req.addr == ERR_STATUS_ADDR);
	endproperty
	a_wait: assert property (p_wait)
		else $error("no wait on error status read");

	property p_tx_clear_off;
		!tx_on |=> !st_reg.txbf && !st_reg.txsf;
	endproperty
	a_tx_clear_off: assert property (p_tx_clear_off)
		else $error("transmit flags survive disable");

	property p_buffer_full;
		tx_on && txb_wr |=> st_reg.txbf;
	endproperty
	a_buffer_full: assert property (p_buffer_full)
		else $error("buffer full flag not set");

	property p_move;
		move |=> tx_load && st_reg.txsf && tx_data == $past(st_reg.txb_data);
	endproperty
	a_move: assert property (p_move)
		else $error("shifter load wrong");

	property p_sel_upper;
		rd_sel |=> bus_rdata[7:4] == 4'h0;
	endproperty
	a_sel_upper: assert property (p_sel_upper)
		else $error("clock select upper bits set");

	property p_div_one;
		interface_power_bit && st_reg.clk_sel == 4'h0 |-> base_clk_en;
	endproperty
	a_div_one: assert property (p_div_one)
		else $error("undivided base clock missing");

	property p_div_two;
		interface_power_bit && st_reg.clk_sel == 4'h1 && base_clk_en
			|=> !base_clk_en;
	endproperty
	a_div_two: assert property (p_div_two)
		else $error("divide by two wrong");

	property p_power_off;
		!interface_power_bit |-> !base_clk_en;
	endproperty
	a_power_off: assert property (p_power_off)
		else $error("base clock runs with power off");

	property p_none_parity;
		rx_eval && parity_mode == PAR_NONE && !st_reg.err[PE_POS]
			|=> !st_reg.err[PE_POS];
	endproperty
	a_none_parity: assert property (p_none_parity)
		else $error("parity flagged with parity off");

	property p_overrun_keep;
		rx_eval && !fifo_ready && !rx_out_ready
			|=> rx_out_data == $past(rx_out_data);
	endproperty
	a_overrun_keep: assert property (p_overrun_keep)
		else $error("overrun replaced buffered data");

	property p_rx_push;
		rx_eval && fifo_ready |=> rx_out_valid;
	endproperty
	a_rx_push: assert property (p_rx_push)
		else $error("evaluated frame not buffered");

	property p_rdata_idle;
		!bus_req.rd |=> bus_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data without a read");

	property p_tx_status_read;
		rd_tx |=> bus_rdata[7:2] == 6'h00
			&& bus_rdata[1:0] == {$past(st_reg.txbf), $past(st_reg.txsf)};
	endproperty
	a_tx_status_read: assert property (p_tx_status_read)
		else $error("transmit status read data wrong");

	property p_buffer_moves;
		move && !txb_wr |=> !st_reg.txbf;
	endproperty
	a_buffer_moves: assert property (p_buffer_moves)
		else $error("buffer full flag kept after move");

	property p_busy_clear;
		tx_on && base_clk_en && tx_frame_done && !st_reg.txbf
			|=> !st_reg.txsf;
	endproperty
	a_busy_clear: assert property (p_busy_clear)
		else $error("busy flag kept after last frame");

	property p_sel_write;
		wr_sel |=> st_reg.clk_sel == $past(bus_req.wdata[3:0]);
	endproperty
	a_sel_write: assert property (p_sel_write)
		else $error("clock select write lost");

	property p_sel_hold;
		!wr_sel |=> st_reg.clk_sel == $past(st_reg.clk_sel);
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("clock select changed without write");

	property p_div_four;
		interface_power_bit && st_reg.clk_sel == 4'h2 && base_clk_en
			&& !wr_sel |=> !base_clk_en [*3];
	endproperty
	a_div_four: assert property (p_div_four)
		else $error("divide by four wrong");

	property p_timer_once;
		st_reg.clk_sel == SEL_TIMER && base_clk_en && !wr_sel
			|=> !base_clk_en;
	endproperty
	a_timer_once: assert property (p_timer_once)
		else $error("timer level gave repeated ticks");

	c_overrun: cover property (rx_eval && !fifo_ready);
	c_parity: cover property (rx_eval && par_err);
	c_back_to_back: cover property (move ##[1:50] move);
	c_timer_clock: cover property (st_reg.clk_sel == SEL_TIMER && base_clk_en);
	c_framing: cover property (rx_eval && !rx_frame.stop_bit);
endmodule
`default_nettype wire

// ===== tb/usc_remote_model.sv
// Remote serial station: offers received frames, drains sent frames
// Assumes base_clk_en from the status block and requests from the bench
`timescale 1ns/1ns
`default_nettype none
module usc_remote_model #(
	parameter int FRAME_TICKS = 12
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic base_clk_en,
	input wire logic send,
	input wire logic [9:0] send_bits,
	output usc_pkg::usc_rx_frame_type rx_frame,
	input wire logic tx_load,
	output logic tx_frame_done
);
	import usc_pkg::*;
	logic pend_reg;
	logic [9:0] bits_reg;
	int cnt_reg;
	// Frame waits for a base tick; lines invert once released
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg <= 1'b0;
			bits_reg <= 10'h000;
			cnt_reg <= 0;
		end else begin
			if (send) begin
				pend_reg <= 1'b1;
				bits_reg <= send_bits;
			end else if (pend_reg && base_clk_en) begin
				pend_reg <= 1'b0;
				bits_reg <= ~bits_reg;
			end
			if (tx_load) begin
				cnt_reg <= FRAME_TICKS;
			end else if (base_clk_en && cnt_reg > 0) begin
				cnt_reg <= cnt_reg - 1;
			end
		end
	end
	// Single stop bit offered, as the receiver samples only the first
	assign rx_frame = {pend_reg & base_clk_en, bits_reg};
	assign tx_frame_done = base_clk_en && cnt_reg == 1;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench of the serial status and clock select block
// Assumes the remote station model stands on the shifter side
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import usc_pkg::*;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	usc_bus_req_type bus_req = '0;
	logic [7:0] bus_rdata, rx_out_data, tx_data, txb_wdata = 8'h00;
	logic bus_wait, base_clk_en, rx_out_valid, tx_load, tx_frame_done;
	logic pwr = 1'b0, rxe = 1'b0, txe = 1'b0, tmr = 1'b0, rdy = 1'b1;
	logic txb_wr = 1'b0, send = 1'b0, cl8 = 1'b1;
	logic [9:0] send_bits = 10'h000;
	usc_parity_type par = PAR_NONE;
	usc_rx_frame_type rx_frame;
	int fails = 0;
	int num_checks = 0;
	// Clock of 4 ns
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	usc_uart_status dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.bus_req(bus_req), .bus_rdata(bus_rdata), .bus_wait(bus_wait),
		.interface_power_bit(pwr), .receive_enable_bit(rxe),
		.transmit_enable_bit(txe), .parity_mode(par), .char_len8(cl8),
		.timer_out(tmr), .base_clk_en(base_clk_en), .rx_frame(rx_frame),
		.rx_out_valid(rx_out_valid), .rx_out_ready(rdy),
		.rx_out_data(rx_out_data), .txb_wr(txb_wr), .txb_wdata(txb_wdata),
		.tx_load(tx_load), .tx_data(tx_data),
		.tx_frame_done(tx_frame_done));
	usc_remote_model far (.clk_sys(clk_sys), .arst_n(arst_n),
		.base_clk_en(base_clk_en), .send(send), .send_bits(send_bits),
		.rx_frame(rx_frame), .tx_load(tx_load),
		.tx_frame_done(tx_frame_done));
	task automatic end_of_test;
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		bus_req.rd = 1'b1;
		bus_req.addr = a;
		#1 check({7'h00, bus_wait}, {7'h00, a == ERR_STATUS_ADDR});
		@(negedge clk_sys);
		bus_req.rd = 1'b0;
		check(bus_rdata, exp);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		bus_req.wr = 1'b1;
		bus_req.addr = a;
		bus_req.wdata = d;
		@(negedge clk_sys);
		bus_req.wr = 1'b0;
	endtask
	// Counts base ticks over n cycles, optionally toggling the timer
	task automatic ticks(input int n, input bit tog, input logic [7:0] exp);
		logic [7:0] c;
		c = 8'h00;
		repeat (n) begin
			@(negedge clk_sys);
			tmr = tog ? ~tmr : 1'b0;
			#1 c = c + {7'h00, base_clk_en};
		end
		check(c, exp);
	endtask
	task automatic frame(input logic [7:0] d, input logic p, input logic s);
		@(negedge clk_sys);
		send = 1'b1;
		send_bits = {d, p, s};
		@(negedge clk_sys);
		send = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic txw(input logic [7:0] d);
		int n;
		@(negedge clk_sys);
		txb_wr = 1'b1;
		txb_wdata = d;
		@(negedge clk_sys);
		txb_wr = 1'b0;
		n = 0;
		while (tx_load !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 100) begin
			fails++;
			end_of_test();
		end else begin
			check(tx_data, d);
		end
	endtask
	// Main sequence
	initial begin
		logic e;
		repeat (16) @(negedge clk_sys);
		arst_n = 1'b1;
		rd(ERR_STATUS_ADDR, 8'h00);
		rd(TX_STATUS_ADDR, 8'h00);
		rd(CLK_SEL_ADDR, 8'h00);
		rd(16'hFF54, 8'h00);
		wr(ERR_STATUS_ADDR, 8'hFF);
		rd(ERR_STATUS_ADDR, 8'h00);
		wr(CLK_SEL_ADDR, 8'h5A);
		rd(CLK_SEL_ADDR, 8'h0A);
		wr(CLK_SEL_ADDR, 8'h02);
		pwr = 1'b1;
		ticks(16, 1'b0, 8'h04);
		pwr = 1'b0;
		wr(CLK_SEL_ADDR, {4'h0, SEL_TIMER});
		pwr = 1'b1;
		ticks(16, 1'b1, 8'h08);
		pwr = 1'b0;
		wr(CLK_SEL_ADDR, 8'h00);
		pwr = 1'b1;
		ticks(16, 1'b0, 8'h10);
		for (int m = 0; m < 4; m++) begin
			for (int p = 0; p < 2; p++) begin
				rxe = 1'b0;
				par = usc_parity_type'(m);
				repeat (2) @(negedge clk_sys);
				rxe = 1'b1;
				repeat (2) @(negedge clk_sys);
				e = (m == 2 && p == 0) || (m == 3 && p == 1);
				frame(8'h03, p[0], 1'b1);
				rd(ERR_STATUS_ADDR, {5'h00, e, 2'h0});
			end
		end
		// Seven-bit frames leave bit 7 out of data and parity
		cl8 = 1'b0;
		rdy = 1'b0;
		frame(8'hC5, 1'b1, 1'b1);
		rd(ERR_STATUS_ADDR, 8'h00);
		check({7'h00, rx_out_valid}, 8'h01);
		check(rx_out_data, 8'h45);
		rdy = 1'b1;
		cl8 = 1'b1;
		frame(8'h55, 1'b0, 1'b0);
		rd(ERR_STATUS_ADDR, 8'h02);
		rd(ERR_STATUS_ADDR, 8'h00);
		frame(8'h55, 1'b0, 1'b0);
		rxe = 1'b0;
		par = PAR_NONE;
		repeat (2) @(negedge clk_sys);
		rxe = 1'b1;
		rd(ERR_STATUS_ADDR, 8'h00);
		rdy = 1'b0;
		for (int i = 0; i < 33; i++) begin
			if (i == 16) begin
				wr(CLK_SEL_ADDR, 8'h00);
			end
			frame(i[7:0], 1'b0, 1'b1);
		end
		rd(ERR_STATUS_ADDR, 8'h01);
		@(negedge clk_sys);
		rdy = 1'b1;
		for (int i = 0; i < 32; i++) begin
			check({rx_out_valid, rx_out_data[6:0]}, {1'b1, i[6:0]});
			@(negedge clk_sys);
		end
		check({7'h00, rx_out_valid}, 8'h00);
		txe = 1'b1;
		repeat (2) @(negedge clk_sys);
		txw(8'hA5);
		rd(TX_STATUS_ADDR, 8'h01);
		txw(8'h3C);
		rd(TX_STATUS_ADDR, 8'h01);
		wr(CLK_SEL_ADDR, 8'h00);
		repeat (14) @(negedge clk_sys);
		rd(TX_STATUS_ADDR, 8'h00);
		txw(8'h11);
		txe = 1'b0;
		@(negedge clk_sys);
		rd(TX_STATUS_ADDR, 8'h00);
		rdy = 1'b0;
		frame(8'h66, 1'b0, 1'b0);
		pwr = 1'b0;
		@(negedge clk_sys);
		pwr = 1'b1;
		rd(ERR_STATUS_ADDR, 8'h00);
		check({7'h00, rx_out_valid}, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
